// ===== inc/crdbk_pkg.sv
/*
  Shared constants of the conversion-data readback path: command opcodes,
  data-sequence layout, status byte bit positions and timing figures.
  Assumes a 200 MHz system clock; no register bus reaches this block.
*/
package crdbk_pkg;

  // Read command opcodes, two codes per converter
  localparam logic [7:0] OP_READ_MAIN_A = 8'h12;
  localparam logic [7:0] OP_READ_MAIN_B = 8'h13;
  localparam logic [7:0] OP_READ_AUX_A  = 8'h14;
  localparam logic [7:0] OP_READ_AUX_B  = 8'h15;

  // Sequence layout
  localparam logic [7:0] PAD_BYTE       = 8'h00;
  localparam logic [7:0] CHECK_OFFSET   = 8'h9B;
  localparam logic [2:0] DATA_BYTES     = 3'h4;
  localparam logic [2:0] LAST_BIT       = 3'h7;

  // Status byte bit positions
  localparam int ST_AUX_NEW  = 7;
  localparam int ST_MAIN_NEW = 6;
  localparam int ST_EXT_CLK  = 5;
  localparam int ST_ALARM_HI = 4;
  localparam int ST_ALARM_LO = 1;
  localparam int ST_RESET    = 0;

  // Configuration register holding the status enable, and its bit
  localparam logic [7:0] CFG_INTERFACE_ADDR = 8'h02;
  localparam int         CFG_STATUS_EN_BIT  = 2;

  // Host must finish direct readback this many master-clock cycles early
  localparam int READ_GUARD_CLK = 16;

  // Check byte modes
  localparam logic [1:0] CHK_OFF = 2'h0;

  // Transfer state
  typedef enum logic [0:0] {
    ST_DIRECT,
    ST_CMD_READ
  } crdbk_state_e;

endpackage : crdbk_pkg

// ===== design/crdbk_sync.sv
/*
  Two-flop synchroniser for a bundle of independent level inputs.
  Assumes each bit is a slow level or a link clock well below clk.
*/
`timescale 1ns/1ps
module crdbk_sync #(
  parameter int       WIDTH = 1,
  parameter bit [0:0] INIT  = 1'b0
) (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic [WIDTH-1:0] async,
  output logic      [WIDTH-1:0] synced
);

  logic [WIDTH-1:0] stage1;

  // First stage feeds only the second
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stage1 <= {WIDTH{INIT}};
      synced <= {WIDTH{INIT}};
    end else begin
      stage1 <= async;
      synced <= stage1;
    end
  end

endmodule : crdbk_sync

// ===== design/crdbk_readback.sv
/*
  Serial readback of main (32-bit) and auxiliary (24-bit) conversion results:
  direct readback from the output shift register and readback by command
  from the holding registers, with optional status and check bytes.
  Assumes the serial pins are asynchronous to clk and much slower than it;
  converter results, alarms and config levels come from clk-domain logic.
*/
// Behaviour
// - Direct readback streams shift register, no opcode
// - Commands decoded during readback; idle input low
// - New result during access goes holding only
// - Restarting config write clears holding register
// - Main sequence is four to six bytes
// - Extra clocks repeat sequence from first byte
// - Ready high on first fall in continuous mode, else on conversion start
// - Output pin goes low with data ready while not transmitting
// - Read command returns holding register unless a command read is running
// - New-data flags one if new, else zero
// - Auxiliary results only through read commands
// - Data MSB at first rise after command
// - Aux block: status, three bytes, pad, check
// - Other commands ignored until read completes
// - Opcodes 12h/13h main, 14h/15h auxiliary
// - Disabled status byte omitted, rest shifted forward
// - Status byte leads only when enabled
// - Status bit 5 shows external clock
// - Status bits 4..1 carry alarms
// - Status bit 0 mirrors reset flag
// - Input on falling, output on rising edges
// - Chip select high resets the interface
// - Main result sent MSB first, 32 bits
// - Check byte is byte sum plus 9Bh
`timescale 1ns/1ps
module crdbk_readback
  import crdbk_pkg::*;
#(
  parameter int MAIN_W = 32,
  parameter int AUX_W  = 24
) (
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic              sclkPin,
  input  wire logic              csPin_n,
  input  wire logic              dinPin,
  input  wire logic [MAIN_W-1:0] mainResult,
  input  wire logic              mainValid,
  input  wire logic [AUX_W-1:0]  auxResult,
  input  wire logic              auxValid,
  input  wire logic              convStart,
  input  wire logic              convRestart,
  input  wire logic              contMode,
  input  wire logic              regAccessBusy,
  input  wire logic              statusByteEnable,
  input  wire logic [1:0]        checkMode,
  input  wire logic              extClockFlag,
  input  wire logic [3:0]        alarms,
  input  wire logic              resetFlag,
  output logic                   dataReady_n,
  output logic                   doutReadyPin,
  output logic                   doutEnable_n,
  output logic                   cmdStrobe,
  output logic [7:0]             cmdCode
);

  logic [2:0]        pinSync;
  logic              sclkPrev;
  logic [2:0]        rxCnt;
  logic [6:0]        rxShift;
  crdbk_state_e      state;
  crdbk_state_e      next_state;
  logic              txActive;
  logic              next_txActive;
  logic [2:0]        bitIdx;
  logic [2:0]        next_bitIdx;
  logic [2:0]        byteIdx;
  logic [2:0]        next_byteIdx;
  logic [31:0]       seqData;
  logic [31:0]       next_seqData;
  logic [7:0]        seqStatus;
  logic [7:0]        next_seqStatus;
  logic [MAIN_W-1:0] mainShift;
  logic [MAIN_W-1:0] mainHold;
  logic [AUX_W-1:0]  auxHold;
  logic              mainNew;
  logic              auxNew;
  logic              next_dataReady_n;
  logic              clearMain;
  logic              clearAux;

  // Byte of the sequence at a given index; status byte optional up front
  function automatic logic [7:0] seq_byte(input logic [2:0]  idx,
                                          input logic        stEn,
                                          input logic [7:0]  st,
                                          input logic [31:0] d);
    logic [2:0] pos;
    logic [7:0] sum;
    pos = stEn ? idx : idx + 3'h1;
    sum = d[31:24] + d[23:16] + d[15:8] + d[7:0] + CHECK_OFFSET;
    case (pos)
      3'h0:    seq_byte = st;
      3'h1:    seq_byte = d[31:24];
      3'h2:    seq_byte = d[23:16];
      3'h3:    seq_byte = d[15:8];
      3'h4:    seq_byte = d[7:0];
      default: seq_byte = sum;
    endcase
  endfunction : seq_byte

  // Pins cross into clk before anything reads them
  crdbk_sync #(.WIDTH(3), .INIT(1'b0)) crdbk_sync_i (
    .clk    (clk),
    .nrst   (nrst),
    .async  ({~csPin_n, sclkPin, dinPin}),
    .synced (pinSync)
  );

  // Edge and decode wires
  wire        csActive  = pinSync[2];
  wire        sclkS     = pinSync[1];
  wire        dinS      = pinSync[0];
  wire        sclkRise  = csActive && sclkS && !sclkPrev;
  wire        sclkFall  = csActive && !sclkS && sclkPrev;
  wire        rxDone    = sclkFall && (rxCnt == LAST_BIT);
  wire [7:0]  rxByte    = {rxShift, dinS};
  wire        isMainCmd = (rxByte == OP_READ_MAIN_A) || (rxByte == OP_READ_MAIN_B);
  wire        isAuxCmd  = (rxByte == OP_READ_AUX_A) || (rxByte == OP_READ_AUX_B);
  wire        cmdOk     = rxDone && (state == ST_DIRECT);
  wire        startMain = cmdOk && isMainCmd;
  wire        startAux  = cmdOk && isAuxCmd;
  wire        execOther = cmdOk && !isMainCmd && !isAuxCmd;
  wire        chkEn     = (checkMode != CHK_OFF);
  wire [2:0]  seqLen    = DATA_BYTES + {2'h0, statusByteEnable} + {2'h0, chkEn};
  wire        lastByte  = (byteIdx == seqLen - 3'h1);
  wire        xferBusy  = txActive || (state == ST_CMD_READ) || regAccessBusy;
  wire [7:0]  statusNow = {auxNew, mainNew, extClockFlag, alarms, resetFlag};
  wire        directGo  = sclkRise && !txActive && (state == ST_DIRECT);
  wire [7:0]  outByte   = seq_byte(next_byteIdx, statusByteEnable, next_seqStatus,
                                   next_seqData);

  // Transmit sequencing; output bits advance on rising edges only
  always_comb begin
    next_state     = state;
    next_txActive  = txActive;
    next_bitIdx    = bitIdx;
    next_byteIdx   = byteIdx;
    next_seqData   = seqData;
    next_seqStatus = seqStatus;
    clearMain      = 1'b0;
    clearAux       = 1'b0;
    if (!csActive) begin
      next_state    = ST_DIRECT;
      next_txActive = 1'b0;
    end else if (startMain || startAux) begin
      next_state     = ST_CMD_READ;
      next_txActive  = 1'b0;
      next_seqStatus = statusNow;
      next_seqData   = startAux ? {auxHold, PAD_BYTE} : mainHold;
      clearMain      = startMain;
      clearAux       = startAux;
    end else if (directGo) begin
      next_txActive  = 1'b1;
      next_bitIdx    = 3'h0;
      next_byteIdx   = 3'h0;
      next_seqStatus = statusNow;
      next_seqData   = mainShift;
      clearMain      = 1'b1;
    end else if (sclkRise && !txActive) begin
      next_txActive = 1'b1;
      next_bitIdx   = 3'h0;
      next_byteIdx  = 3'h0;
    end else if (sclkRise) begin
      next_bitIdx = bitIdx + 3'h1;
      if (bitIdx == LAST_BIT) begin
        next_byteIdx = lastByte ? 3'h0 : byteIdx + 3'h1;
        if (lastByte) begin
          next_state = ST_DIRECT;
        end
      end
    end
  end

  // Data ready: low on a fresh main result
  always_comb begin
    next_dataReady_n = dataReady_n;
    if (mainValid) begin
      next_dataReady_n = 1'b0;
    end else if (contMode && sclkFall) begin
      next_dataReady_n = 1'b1;
    end else if (!contMode && convStart) begin
      next_dataReady_n = 1'b1;
    end
  end

  // Serial front end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sclkPrev <= 1'b0;
      rxCnt    <= 3'h0;
      rxShift  <= 7'h00;
    end else begin
      sclkPrev <= sclkS;
      if (!csActive) begin
        rxCnt <= 3'h0;
      end else if (sclkFall) begin
        rxCnt   <= rxCnt + 3'h1;
        rxShift <= rxByte[6:0];
      end
    end
  end

  // Transmit registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state     <= ST_DIRECT;
      txActive  <= 1'b0;
      bitIdx    <= 3'h0;
      byteIdx   <= 3'h0;
      seqData   <= 32'h0000_0000;
      seqStatus <= 8'h00;
    end else begin
      state     <= next_state;
      txActive  <= next_txActive;
      bitIdx    <= next_bitIdx;
      byteIdx   <= next_byteIdx;
      seqData   <= next_seqData;
      seqStatus <= next_seqStatus;
    end
  end

  // Result storage; shift register frozen while any access runs
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mainShift <= '0;
      mainHold  <= '0;
      auxHold   <= '0;
    end else begin
      if (mainValid) begin
        mainHold <= mainResult;
      end else if (convRestart) begin
        mainHold <= '0;
      end
      if (mainValid && !xferBusy) begin
        mainShift <= mainResult;
      end
      if (auxValid) begin
        auxHold <= auxResult;
      end
    end
  end

  // New-data flags: a fresh result wins over a same-cycle clear
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mainNew <= 1'b0;
      auxNew  <= 1'b0;
    end else begin
      mainNew <= mainValid || (mainNew && !clearMain && !convRestart);
      auxNew  <= auxValid || (auxNew && !clearAux);
    end
  end

  // Pin outputs; while not transmitting the pin takes the next ready value, so they move together
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dataReady_n  <= 1'b1;
      doutReadyPin <= 1'b1;
      doutEnable_n <= 1'b1;
      cmdStrobe    <= 1'b0;
      cmdCode      <= 8'h00;
    end else begin
      dataReady_n  <= next_dataReady_n;
      doutReadyPin <= next_txActive ? outByte[LAST_BIT - next_bitIdx] : next_dataReady_n;
      doutEnable_n <= !csActive;
      cmdStrobe    <= execOther;
      if (execOther) begin
        cmdCode <= rxByte;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_direct_start: assert property (directGo && csActive |=> txActive && bitIdx == 3'h0)
    else $error("direct readback did not start");
  a_shift_frozen: assert property (mainValid && xferBusy |=> $stable(mainShift))
    else $error("shift register changed during access");
  a_restart_clear: assert property (convRestart && !mainValid |=> mainHold == '0 && !mainNew)
    else $error("restart left old result");
  a_seq_length: assert property (txActive |-> byteIdx < seqLen)
    else $error("sequence index beyond its length");
  a_seq_wrap: assert property (sclkRise && txActive && bitIdx == LAST_BIT && lastByte
                                && csActive |=> byteIdx == 3'h0)
    else $error("sequence did not restart");
  a_ready_cont: assert property (contMode && !dataReady_n && sclkFall && !mainValid
                                 |=> dataReady_n)
    else $error("data ready not released on falling edge");
  a_ready_pin: assert property (!txActive |-> doutReadyPin == dataReady_n)
    else $error("pin not following data ready");
  a_cmd_read: assert property ((startMain || startAux) |=> state == ST_CMD_READ)
    else $error("read command not served");
  a_first_bit: assert property (sclkRise && !txActive |=> txActive && bitIdx == 3'h0)
    else $error("readback did not start at its first bit");
  a_cmd_ignore: assert property (rxDone && state == ST_CMD_READ |=> !cmdStrobe)
    else $error("command accepted during read");
  a_flag_clear: assert property (startMain && !mainValid |=> !mainNew)
    else $error("main new flag not cleared");
  a_cs_reset: assert property (!csActive |=> state == ST_DIRECT && !txActive)
    else $error("interface not reset by chip select");

  c_direct_read: cover property (directGo ##[1:1000] (sclkRise && lastByte && bitIdx == LAST_BIT));
  c_main_cmd: cover property (startMain);
  c_aux_cmd: cover property (startAux);
  c_hold_only: cover property (mainValid && xferBusy);

endmodule : crdbk_readback

// ===== testbench/crdbk_host_model.sv
/*
  Host controller model on the serial pins: clock idles low, MSB first.
  Assumes a 200 MHz clk; serial clock half periods of 8 clk (80 ns period).
*/
`timescale 1ns/1ps
module crdbk_host_model (
  input  wire logic clk,
  input  wire logic doutPin,
  output logic      sclkPin,
  output logic      csPin_n,
  output logic      dinPin
);
  logic [7:0] rxByte;

  // Idle between frames: clock parked low, deselected, data low
  initial begin
    sclkPin = 1'b0;
    csPin_n = 1'b1;
    dinPin  = 1'b0;
    rxByte  = 8'h00;
  end

  // Chip select, with settling time for the pin synchroniser
  task automatic select(input logic en);
    csPin_n <= ~en;
    repeat (8) @(posedge clk);
  endtask : select

  // One byte: drive on the rise, sample late in the high phase
  task automatic xfer(input logic [7:0] tx);
    for (int i = 7; i >= 0; i--) begin
      sclkPin <= 1'b1;
      dinPin  <= tx[i];
      repeat (8) @(posedge clk);
      rxByte[i] = doutPin;
      sclkPin <= 1'b0;
      repeat (8) @(posedge clk);
    end
    dinPin <= 1'b0;
    @(posedge clk);
  endtask : xfer
endmodule : crdbk_host_model

// ===== testbench/conversion_data_readback_bench.sv
/*
  Self-checking bench: converter-side inputs driven here, pins by the host model.
  Assumes the design's pin synchroniser latency and a 200 MHz clk.
*/
`timescale 1ns/1ps
module conversion_data_readback_bench import crdbk_pkg::*;;
  logic        clk;
  logic        nrst;
  logic        mainValid;
  logic        auxValid;
  logic        convStart;
  logic        convRestart;
  logic        contMode;
  logic        regAccessBusy;
  logic        statusByteEnable;
  logic        extClockFlag;
  logic        resetFlag;
  logic [31:0] mainResult;
  logic [23:0] auxResult;
  logic [1:0]  checkMode;
  logic [3:0]  alarms;
  logic        sclkPin, csPin_n, dinPin;
  logic        dataReady_n, doutReadyPin, doutEnable_n, cmdStrobe;
  logic [7:0]  cmdCode;
  wire         doutWire = doutEnable_n ? 1'bz : doutReadyPin;
  int          fails = 0, compares = 0, strobes = 0, cycles = 0, n0 = 0;
  logic [7:0]  exp[$];

  crdbk_readback crdbk_readback_i (.clk(clk), .nrst(nrst), .sclkPin(sclkPin),
    .csPin_n(csPin_n), .dinPin(dinPin), .mainResult(mainResult), .mainValid(mainValid),
    .auxResult(auxResult), .auxValid(auxValid), .convStart(convStart),
    .convRestart(convRestart), .contMode(contMode), .regAccessBusy(regAccessBusy),
    .statusByteEnable(statusByteEnable), .checkMode(checkMode),
    .extClockFlag(extClockFlag), .alarms(alarms), .resetFlag(resetFlag),
    .dataReady_n(dataReady_n), .doutReadyPin(doutReadyPin), .doutEnable_n(doutEnable_n),
    .cmdStrobe(cmdStrobe), .cmdCode(cmdCode));
  crdbk_host_model crdbk_host_model_i (.clk(clk), .doutPin(doutWire), .sclkPin(sclkPin),
    .csPin_n(csPin_n), .dinPin(dinPin));

  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Strobe count and hang guard; a run needs well under 10k cycles
  always @(posedge clk) begin
    cycles++;
    if (cmdStrobe === 1'b1) strobes++;
    if (cycles == 20000) begin
      fails++;
      give_verdict();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
    compares++;
    if (seen !== want) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, want, seen);
    end
  endtask : check

  task automatic give_verdict;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : give_verdict

  function automatic logic [7:0] stat(input logic a, input logic m);
    return {a, m, extClockFlag, alarms, resetFlag};
  endfunction : stat

  // Expected byte order: status, data MSB first, pad, check
  task automatic build(input logic stEn, input logic [7:0] st, input logic [31:0] d,
                       input logic aux, input logic chk);
    logic [7:0] sum;
    sum = CHECK_OFFSET;
    exp.delete();
    if (stEn) exp.push_back(st);
    for (int i = aux ? 2 : 3; i >= 0; i--) begin
      exp.push_back(d[8*i +: 8]);
      sum += d[8*i +: 8];
    end
    if (aux) exp.push_back(PAD_BYTE);
    if (chk) exp.push_back(sum);
  endtask : build

  // Extra bytes past the end wrap to the first byte
  task automatic readback(input logic [7:0] tx, input int extra);
    for (int k = 0; k < exp.size() + extra; k++) begin
      crdbk_host_model_i.xfer(tx);
      check("byte", crdbk_host_model_i.rxByte, exp[k % exp.size()]);
    end
  endtask : readback

  // New results only arrive while no readback runs
  task automatic pulse_main(input logic [31:0] d);
    mainResult <= d;
    mainValid  <= 1'b1;
    @(posedge clk);
    mainValid  <= 1'b0;
  endtask : pulse_main

  task automatic t_direct;
    crdbk_host_model_i.select(1'b1);
    pulse_main(32'h12345678);
    repeat (2) @(posedge clk);
    check("ready low", dataReady_n, 1'b0);
    check("pin low", doutReadyPin, 1'b0);
    check("pin enabled", doutEnable_n, 1'b0);
    build(1'b1, stat(1'b0, 1'b1), 32'h12345678, 1'b0, 1'b1);
    readback(8'h00, 1);
    check("ready high", dataReady_n, 1'b1);
    crdbk_host_model_i.select(1'b0);
  endtask : t_direct

  // Bytes sent during a command read are ignored, later ones decoded
  task automatic t_cmd_main;
    checkMode <= CHK_OFF;
    crdbk_host_model_i.select(1'b1);
    build(1'b1, stat(1'b0, 1'b0), 32'h12345678, 1'b0, 1'b0);
    crdbk_host_model_i.xfer(OP_READ_MAIN_B);
    n0 = strobes;
    readback(8'h08, 0);
    check("ignored", strobes, n0);
    crdbk_host_model_i.xfer(8'h08);
    check("strobe", strobes, n0 + 1);
    check("code", cmdCode, 8'h08);
    crdbk_host_model_i.select(1'b0);
  endtask : t_cmd_main

  task automatic t_aux;
    auxResult <= 24'hA1B2C3;
    auxValid  <= 1'b1;
    @(posedge clk);
    auxValid  <= 1'b0;
    checkMode <= 2'h1;
    extClockFlag <= 1'b0;
    resetFlag    <= 1'b0;
    alarms       <= 4'h5;
    crdbk_host_model_i.select(1'b1);
    build(1'b1, stat(1'b1, 1'b0), 32'hA1B2C3, 1'b1, 1'b1);
    crdbk_host_model_i.xfer(OP_READ_AUX_A);
    readback(8'h00, 0);
    crdbk_host_model_i.select(1'b0);
    checkMode <= CHK_OFF;
    crdbk_host_model_i.select(1'b1);
    build(1'b1, stat(1'b0, 1'b0), 32'hA1B2C3, 1'b1, 1'b0);
    crdbk_host_model_i.xfer(OP_READ_AUX_B);
    readback(8'h00, 1);
    crdbk_host_model_i.select(1'b0);
  endtask : t_aux

  // Result during a register access reaches the holding register only
  task automatic t_busy;
    statusByteEnable <= 1'b0;
    regAccessBusy    <= 1'b1;
    pulse_main(32'hFEDCBA98);
    regAccessBusy    <= 1'b0;
    crdbk_host_model_i.select(1'b1);
    build(1'b0, 8'h00, 32'h12345678, 1'b0, 1'b0);
    readback(8'h00, 0);
    crdbk_host_model_i.select(1'b0);
    crdbk_host_model_i.select(1'b1);
    build(1'b0, 8'h00, 32'hFEDCBA98, 1'b0, 1'b0);
    crdbk_host_model_i.xfer(OP_READ_MAIN_A);
    readback(8'h00, 0);
    crdbk_host_model_i.select(1'b0);
  endtask : t_busy

  // Restart empties holding register; deselect aborts a read
  task automatic t_restart;
    convRestart      <= 1'b1;
    statusByteEnable <= 1'b1;
    @(posedge clk);
    convRestart      <= 1'b0;
    crdbk_host_model_i.select(1'b1);
    build(1'b1, stat(1'b0, 1'b0), 32'h0, 1'b0, 1'b0);
    crdbk_host_model_i.xfer(OP_READ_MAIN_A);
    readback(8'h00, 0);
    crdbk_host_model_i.xfer(OP_READ_MAIN_B);
    crdbk_host_model_i.xfer(8'h00);
    crdbk_host_model_i.select(1'b0);
    crdbk_host_model_i.select(1'b1);
    n0 = strobes;
    crdbk_host_model_i.xfer(8'h08);
    check("after abort", strobes, n0 + 1);
    crdbk_host_model_i.select(1'b0);
  endtask : t_restart

  task automatic t_pulse;
    contMode <= 1'b0;
    crdbk_host_model_i.select(1'b1);
    pulse_main(32'h0F0F0F0F);
    crdbk_host_model_i.xfer(8'h00);
    check("ready held", dataReady_n, 1'b0);
    convStart <= 1'b1;
    @(posedge clk);
    convStart <= 1'b0;
    repeat (2) @(posedge clk);
    check("ready freed", dataReady_n, 1'b1);
    crdbk_host_model_i.select(1'b0);
  endtask : t_pulse

  // Main sequence; levels set once here, then varied by the scenarios
  initial begin
    nrst             <= 1'b0;
    mainValid        <= 1'b0;
    auxValid         <= 1'b0;
    convStart        <= 1'b0;
    convRestart      <= 1'b0;
    contMode         <= 1'b1;
    regAccessBusy    <= 1'b0;
    statusByteEnable <= 1'b1;
    extClockFlag     <= 1'b1;
    resetFlag        <= 1'b1;
    mainResult       <= 32'h0000_0000;
    auxResult        <= 24'h00_0000;
    checkMode        <= 2'h1;
    alarms           <= 4'hA;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    check("reset ready", dataReady_n, 1'b1);
    check("reset enable", doutEnable_n, 1'b1);
    t_direct();
    t_cmd_main();
    t_aux();
    t_busy();
    t_restart();
    t_pulse();
    give_verdict();
  end
endmodule : conversion_data_readback_bench
